// *** hw/dio_consts.svh ***
`ifndef DIO_CONSTS_SVH
`define DIO_CONSTS_SVH

`define IDX_GRP_BIT 2
`define PORT_A 2'h0
`define PORT_B 2'h1
`define PORT_C 2'h2
`define PORT_CFG 2'h3
`define IDX_EVENT_CNT 8'h80
`define IDX_CNT_CFG 8'h83
`define IDX_IRQ_CLEAR 8'h03

`define DIR_A_BIT 4
`define DIR_CU_BIT 3
`define DIR_B_BIT 1
`define DIR_CL_BIT 0
`define CFG_MODE_FLAG_BIT 7
`define CFG_RESET 8'h9B

`define CCW_SEL_HI 7
`define CCW_SEL_LO 6
`define CCW_MODE_HI 2
`define CCW_MODE_LO 1
`define CCW_RATE_MODE 2'h2

`define EVENT_IN_BIT 0
`define EDGE_ARM_BIT 3
`define EDGE_QUAL_BIT 7
`define PROG_IRQ_CTRL_BIT 4

`define CLK_HZ 125000000
`define PACER_FAST_HZ 2000000
`define PACER_SLOW_HZ 32768

`define IRQ_LINE_DEFAULT 4'h5
`define IRQ_LINE_MIN 4'h3

`endif

// *** hw/dio_pkg.sv ***
package dio_pkg;

    typedef struct packed {
        logic [7:0] c;
        logic [7:0] b;
        logic [7:0] a;
    } port_pins_type;

    typedef struct packed {
        logic a_in;
        logic c_hi_in;
        logic b_in;
        logic c_lo_in;
    } dir_type;

    typedef struct packed {
        logic [3:0] irq_line_select;
        logic timer_irq_enable;
        logic event_irq_enable;
        logic timer_clock_select;
        logic grp0_edge_irq_setting;
        logic grp1_edge_irq_setting;
    } jumper_type;

endpackage

// *** hw/dio_timer_card.sv ***
`timescale 1ns/1ns
`include "dio_consts.svh"

module dio_timer_card
(
    input wire logic clk,
    input wire logic srst,
    input wire logic host_cs,
    input wire logic host_addr,
    input wire logic host_wr,
    input wire logic host_rd,
    input wire logic [7:0] host_wdata,
    output logic [7:0] host_rdata,
    input wire dio_pkg::port_pins_type [1:0] pin_in,
    output logic [47:0] pin_out,
    output logic [47:0] pin_oe,
    input wire dio_pkg::jumper_type jumpers,
    output logic [15:0] irq_out
);

    localparam int SYNC_W = 2 * $bits(dio_pkg::port_pins_type) + $bits(dio_pkg::jumper_type);
    localparam logic [31:0] STEP_FAST = 32'((64'(`PACER_FAST_HZ) << 32) / 64'(`CLK_HZ));
    localparam logic [31:0] STEP_SLOW = 32'((64'(`PACER_SLOW_HZ) << 32) / 64'(`CLK_HZ));

    // ----------------------------------------
    // pin and jumper synchronisers
    // ----------------------------------------
    logic [SYNC_W-1:0] sync1_r;
    logic [SYNC_W-1:0] sync2_r;
    dio_pkg::port_pins_type [1:0] pin_s;
    dio_pkg::jumper_type jmp_s;
    logic [1:0] settle_r;
    logic settled;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
        end
        else
        begin
            sync1_r <= {pin_in, jumpers};
            sync2_r <= sync1_r;
        end
    end

    assign {pin_s, jmp_s} = sync2_r;

    // edges are ignored until the synchronisers hold real pin levels
    always_ff @(posedge clk)
    begin
        if (srst)
            settle_r <= 2'h0;
        else if (!settled)
            settle_r <= settle_r + 2'h1;
    end

    assign settled = settle_r == 2'h3;

    // ----------------------------------------
    // host index and data locations
    // ----------------------------------------
    logic [7:0] index_select_r;
    logic idx_wr;
    logic data_wr;
    logic data_rd;
    logic grp_hit;
    logic grp_sel;
    logic [1:0] port_sel;

    assign idx_wr = host_cs && host_wr && !host_addr;
    assign data_wr = host_cs && host_wr && host_addr;
    assign data_rd = host_cs && host_rd && host_addr;
    assign grp_hit = index_select_r[7:3] == 5'h00;
    assign grp_sel = index_select_r[`IDX_GRP_BIT];
    assign port_sel = index_select_r[1:0];

    always_ff @(posedge clk)
    begin
        if (srst)
            index_select_r <= 8'h00;
        else if (idx_wr)
            index_select_r <= host_wdata;
    end

    // ----------------------------------------
    // port groups
    // ----------------------------------------
    function automatic dio_pkg::dir_type cfg_to_dir(input logic [7:0] cfg);
        cfg_to_dir = {cfg[`DIR_A_BIT], cfg[`DIR_CU_BIT], cfg[`DIR_B_BIT], cfg[`DIR_CL_BIT]};
    endfunction

    wire dio_pkg::port_pins_type eff [2];
    wire dio_pkg::port_pins_type out_w [2];
    wire dio_pkg::port_pins_type oe_w [2];
    wire dio_pkg::dir_type dir_w [2];
    wire [1:0] edge_hit;

    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : grp
            dio_pkg::dir_type dir_r;
            dio_pkg::port_pins_type out_r;
            logic arm_prev_r;
            logic qual_prev_r;
            logic sel_wr;
            logic arm;
            logic qual;

            assign sel_wr = data_wr && grp_hit && (grp_sel == 1'(g));

            always_ff @(posedge clk)
            begin
                if (srst)
                begin
                    dir_r <= cfg_to_dir(`CFG_RESET);
                    out_r <= '0;
                end
                else if (sel_wr)
                begin
                    unique case (port_sel)
                        `PORT_A: out_r.a <= host_wdata;
                        `PORT_B: out_r.b <= host_wdata;
                        `PORT_C: out_r.c <= host_wdata;
                        `PORT_CFG:
                            if (host_wdata[`CFG_MODE_FLAG_BIT])
                            begin
                                dir_r <= cfg_to_dir(host_wdata);
                                out_r <= '0;
                            end
                            else
                                out_r.c[host_wdata[3:1]] <= host_wdata[0];
                    endcase
                end
            end

            // inputs read live, outputs read back their latch
            assign eff[g] = {dir_r.c_hi_in ? pin_s[g].c[7:4] : out_r.c[7:4],
                             dir_r.c_lo_in ? pin_s[g].c[3:0] : out_r.c[3:0],
                             dir_r.b_in ? pin_s[g].b : out_r.b,
                             dir_r.a_in ? pin_s[g].a : out_r.a};
            assign oe_w[g] = {{4{!dir_r.c_hi_in}}, {4{!dir_r.c_lo_in}},
                              {8{!dir_r.b_in}}, {8{!dir_r.a_in}}};
            assign out_w[g] = out_r;
            assign dir_w[g] = dir_r;

            assign arm = eff[g].c[`EDGE_ARM_BIT];
            assign qual = eff[g].c[`EDGE_QUAL_BIT];

            always_ff @(posedge clk)
            begin
                if (srst)
                begin
                    arm_prev_r <= 1'b0;
                    qual_prev_r <= 1'b0;
                end
                else
                begin
                    arm_prev_r <= arm;
                    qual_prev_r <= qual;
                end
            end

            assign edge_hit[g] = settled && ((arm && !arm_prev_r && !qual)
                || (arm && qual_prev_r && !qual));
        end
    endgenerate

    assign pin_out = {out_w[1], out_w[0]};
    assign pin_oe = {oe_w[1], oe_w[0]};

    // ----------------------------------------
    // pacer clock and counters
    // ----------------------------------------
    logic [31:0] phase_r;
    logic pacer_tick_r;
    logic [32:0] phase_sum;
    logic ev_prev_r;
    logic event_tick;
    logic [7:0] ccw_r;
    logic ccw_wr;
    logic cnt_hit;
    wire [2:0] cnt_tc;
    wire [2:0] cnt_tick;
    wire [7:0] cnt_rd [3];

    // fractional accumulator gives the average rate of the chosen source
    assign phase_sum = {1'b0, phase_r}
        + {1'b0, jmp_s.timer_clock_select ? STEP_FAST : STEP_SLOW};

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            phase_r <= 32'h0000_0000;
            pacer_tick_r <= 1'b0;
        end
        else
        begin
            phase_r <= phase_sum[31:0];
            pacer_tick_r <= phase_sum[32];
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            ev_prev_r <= 1'b0;
        else
            ev_prev_r <= eff[0].c[`EVENT_IN_BIT];
    end

    assign event_tick = settled && eff[0].c[`EVENT_IN_BIT] && !ev_prev_r;
    assign cnt_tick = {cnt_tc[1], pacer_tick_r, event_tick};
    assign ccw_wr = data_wr && index_select_r == `IDX_CNT_CFG;
    assign cnt_hit = index_select_r[7:2] == 6'h20 && index_select_r[1:0] != 2'h3;

    always_ff @(posedge clk)
    begin
        if (srst)
            ccw_r <= 8'h00;
        else if (ccw_wr)
            ccw_r <= host_wdata;
    end

    genvar c;
    generate
        for (c = 0; c < 3; c++)
        begin : cnt
            pacer_down_counter u_cnt
            (
                .clk(clk),
                .srst(srst),
                .data_we(data_wr && index_select_r == 8'(`IDX_EVENT_CNT + c)),
                .data_re(data_rd && index_select_r == 8'(`IDX_EVENT_CNT + c)),
                .wdata(host_wdata),
                .ctrl_we(ccw_wr && host_wdata[`CCW_SEL_HI:`CCW_SEL_LO] == 2'(c)),
                .rate_mode(host_wdata[`CCW_MODE_HI:`CCW_MODE_LO] == `CCW_RATE_MODE),
                .tick(cnt_tick[c]),
                .rd_byte(cnt_rd[c]),
                .tc_pulse(cnt_tc[c])
            );
        end
    endgenerate

    // ----------------------------------------
    // interrupt request
    // ----------------------------------------
    logic timer_evt;
    logic count_evt;
    logic edge_evt;
    logic irq_evt;
    logic irq_clear;
    logic irq_pending_r;
    logic irq_armed_r;
    logic [3:0] irq_line;

    assign timer_evt = cnt_tc[2] && jmp_s.timer_irq_enable;
    assign count_evt = cnt_tc[0] && jmp_s.event_irq_enable;
    assign edge_evt = eff[0].c[`PROG_IRQ_CTRL_BIT]
        && ((edge_hit[0] && jmp_s.grp0_edge_irq_setting)
        || (edge_hit[1] && jmp_s.grp1_edge_irq_setting));
    assign irq_evt = timer_evt || count_evt || edge_evt;
    assign irq_clear = data_rd && index_select_r == `IDX_IRQ_CLEAR;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            irq_pending_r <= 1'b0;
            irq_armed_r <= 1'b1;
        end
        else if (irq_clear)
        begin
            irq_pending_r <= irq_evt;
            irq_armed_r <= !irq_evt;
        end
        else if (irq_evt && irq_armed_r)
        begin
            irq_pending_r <= 1'b1;
            irq_armed_r <= 1'b0;
        end
    end

    assign irq_line = jmp_s.irq_line_select < `IRQ_LINE_MIN
        ? `IRQ_LINE_DEFAULT : jmp_s.irq_line_select;

    always_ff @(posedge clk)
    begin
        if (srst)
            irq_out <= 16'h0000;
        else
            irq_out <= irq_pending_r ? 16'h0001 << irq_line : 16'h0000;
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    logic [7:0] rd_mux;

    always_comb
    begin
        rd_mux = 8'h00;
        if (!host_addr)
            rd_mux = index_select_r;
        else if (grp_hit)
        begin
            unique case (port_sel)
                `PORT_A: rd_mux = eff[grp_sel].a;
                `PORT_B: rd_mux = eff[grp_sel].b;
                `PORT_C: rd_mux = eff[grp_sel].c;
                `PORT_CFG: rd_mux = {3'h4, dir_w[grp_sel].a_in, dir_w[grp_sel].c_hi_in,
                                     1'b0, dir_w[grp_sel].b_in, dir_w[grp_sel].c_lo_in};
            endcase
        end
        else if (cnt_hit)
            rd_mux = cnt_rd[port_sel];
        else if (index_select_r == `IDX_CNT_CFG)
            rd_mux = ccw_r;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            host_rdata <= 8'h00;
        else if (host_cs && host_rd)
            host_rdata <= rd_mux;
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    AST_IDX_STICKS: assert property (@(posedge clk) disable iff (srst)
        idx_wr |=> index_select_r == $past(host_wdata))
        else $error("index not taken");

    AST_CFG_READBACK: assert property (@(posedge clk) disable iff (srst)
        data_rd && index_select_r == 8'h03 |=> host_rdata[7:5] == 3'h4
        && host_rdata[4] == dir_w[0].a_in && host_rdata[0] == dir_w[0].c_lo_in)
        else $error("group zero config readback wrong");

    AST_OE_FOLLOWS_DIR: assert property (@(posedge clk) disable iff (srst)
        data_wr && index_select_r == 8'h07 && host_wdata[7]
        |=> pin_oe[31:24] == {8{!$past(host_wdata[4])}}
        && pin_oe[43:40] == {4{!$past(host_wdata[0])}})
        else $error("direction not applied");

    AST_INPUT_LIVE: assert property (@(posedge clk) disable iff (srst)
        data_rd && index_select_r == 8'h00 && dir_w[0].a_in
        |=> host_rdata == $past(pin_s[0].a))
        else $error("input read not live");

    AST_G0_EDGE: assert property (@(posedge clk) disable iff (srst)
        settled && irq_armed_r && !irq_clear && jmp_s.grp0_edge_irq_setting
        && eff[0].c[4] && eff[0].c[3] && !$past(eff[0].c[3]) && !eff[0].c[7]
        |=> irq_pending_r)
        else $error("qualified edge lost");

    AST_TIMER_GATE: assert property (@(posedge clk) disable iff (srst)
        $rose(irq_pending_r) |-> ($past(cnt_tc[2]) && $past(jmp_s.timer_irq_enable))
        || ($past(cnt_tc[0]) && $past(jmp_s.event_irq_enable)) || $past(edge_evt))
        else $error("interrupt without cause");

    AST_CLEAR_REARM: assert property (@(posedge clk) disable iff (srst)
        irq_clear && !irq_evt |=> !irq_pending_r && irq_armed_r)
        else $error("clear did not re-arm");

    AST_STICKY: assert property (@(posedge clk) disable iff (srst)
        irq_pending_r && !irq_clear |=> irq_pending_r)
        else $error("pending interrupt dropped");

    AST_ONE_LINE: assert property (@(posedge clk) disable iff (srst)
        ##1 irq_out == ($past(irq_pending_r) ? 16'h0001 << $past(irq_line) : 16'h0000))
        else $error("interrupt line routing wrong");

endmodule // dio_timer_card

// *** hw/pacer_down_counter.sv ***
`timescale 1ns/1ns

module pacer_down_counter
(
    input wire logic clk,
    input wire logic srst,
    input wire logic data_we,
    input wire logic data_re,
    input wire logic [7:0] wdata,
    input wire logic ctrl_we,
    input wire logic rate_mode,
    input wire logic tick,
    output logic [7:0] rd_byte,
    output logic tc_pulse
);

    logic [7:0] lo_r;
    logic wr_hi_r;
    logic rd_hi_r;
    logic [15:0] count_r;
    logic [15:0] reload_r;
    logic running_r;
    logic rate_r;
    logic done_r;

    // ----------------------------------------
    // byte pointers
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wr_hi_r <= 1'b0;
            lo_r <= 8'h00;
        end
        else if (ctrl_we)
            wr_hi_r <= 1'b0;
        else if (data_we)
        begin
            wr_hi_r <= !wr_hi_r;
            if (!wr_hi_r)
                lo_r <= wdata;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst || ctrl_we)
            rd_hi_r <= 1'b0;
        else if (data_re)
            rd_hi_r <= !rd_hi_r;
    end

    assign rd_byte = rd_hi_r ? count_r[15:8] : count_r[7:0];

    // ----------------------------------------
    // count
    // ----------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            count_r <= 16'h0000;
            reload_r <= 16'h0000;
            running_r <= 1'b0;
            rate_r <= 1'b0;
            done_r <= 1'b0;
            tc_pulse <= 1'b0;
        end
        else
        begin
            tc_pulse <= 1'b0;
            if (ctrl_we)
            begin
                rate_r <= rate_mode;
                running_r <= 1'b0;
                done_r <= 1'b0;
            end
            else if (data_we && wr_hi_r)
            begin
                count_r <= {wdata, lo_r};
                reload_r <= {wdata, lo_r};
                running_r <= 1'b1;
                done_r <= 1'b0;
            end
            else if (tick && running_r)
            begin
                if (count_r == 16'h0001)
                begin
                    tc_pulse <= rate_r || !done_r;
                    done_r <= 1'b1;
                    count_r <= rate_r ? reload_r : 16'h0000;
                end
                else
                    count_r <= count_r - 16'h0001;
            end
        end
    end

    AST_LOAD_LSB_FIRST: assert property (@(posedge clk) disable iff (srst)
        data_we && wr_hi_r && !ctrl_we |=> count_r == {$past(wdata), $past(lo_r)})
        else $error("counter load order wrong");

    AST_TC_FROM_ONE: assert property (@(posedge clk) disable iff (srst)
        tc_pulse |-> $past(count_r) == 16'h0001 && $past(tick) && $past(running_r))
        else $error("terminal count without reaching one");

endmodule // pacer_down_counter

// *** tb/indexed_dio_timer_card_test.sv ***
`timescale 1ns/1ns

module indexed_dio_timer_card_test;
    logic clk;
    logic srst;
    logic host_cs;
    logic host_addr;
    logic host_wr;
    logic host_rd;
    logic [7:0] host_wdata;
    logic [7:0] host_rdata;
    logic [47:0] pin_out;
    logic [47:0] pin_oe;
    logic [47:0] ext;
    dio_pkg::port_pins_type [1:0] pin_in;
    dio_pkg::jumper_type jumpers;
    logic [15:0] irq_out;
    int num_errors;
    int checks_done;
    logic [7:0] rv;
    logic [7:0] code;
    logic [23:0] tbl [14];

    dio_timer_card DUT
    (
        .clk(clk), .srst(srst), .host_cs(host_cs), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
        .host_rdata(host_rdata), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe(pin_oe), .jumpers(jumpers), .irq_out(irq_out)
    );

    pin_env env
    (
        .pin_out(pin_out), .pin_oe(pin_oe), .ext(ext), .pin_in(pin_in)
    );

    // ----------------------------------------
    // host access tasks
    // ----------------------------------------
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic acc(input logic a, input logic w, input logic [7:0] d);
        @(posedge clk);
        host_cs <= 1'b1;
        host_addr <= a;
        host_wr <= w;
        host_rd <= ~w;
        host_wdata <= d;
        @(posedge clk);
        host_cs <= 1'b0;
        host_wr <= 1'b0;
        host_rd <= 1'b0;
    endtask

    task automatic rd(input logic a, output logic [7:0] d);
        acc(a, 1'b0, 8'h00);
        @(posedge clk);
        #1;
        d = host_rdata;
    endtask

    task automatic put(input logic [7:0] idx, input logic [7:0] d);
        acc(1'b0, 1'b1, idx);
        acc(1'b1, 1'b1, d);
    endtask

    task automatic get(input logic [7:0] idx, output logic [7:0] d);
        acc(1'b0, 1'b1, idx);
        rd(1'b1, d);
    endtask

    task automatic clr;
        get(8'h03, rv);
        wt(1);
    endtask

    task automatic pc(input logic [7:0] c0, input logic [7:0] c1);
        @(posedge clk);
        ext <= {c1, 16'h0000, c0, 16'h0000};
        wt(6);
    endtask

    task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
        checks_done++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic summarize;
        $display("mismatches %0d comparisons %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // ----------------------------------------
    // clock and watchdog
    // ----------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    initial
    begin
        repeat (40000) @(posedge clk);
        num_errors++;
        summarize;
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial
    begin
        srst = 1'b1;
        host_cs = 1'b0;
        host_addr = 1'b0;
        host_wr = 1'b0;
        host_rd = 1'b0;
        host_wdata = 8'h00;
        ext = 48'h0000_0000_0000;
        jumpers = '0;
        jumpers.irq_line_select = 4'h5;
        num_errors = 0;
        checks_done = 0;
        tbl = '{24'h10_0000, 24'h18_0020, 24'h98_0000, 24'h18_0020, 24'h10_0000,
            24'h90_0000, 24'h98_0000, 24'h90_0000, 24'h10_0000, 24'h10_0820,
            24'h10_8800, 24'h10_0820, 24'h00_0000, 24'h08_0000};
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        @(negedge clk);
        chk("rst_oe", 48'h0, pin_oe);
        chk("rst_out", 48'h0, pin_out);
        chk("rst_irq", 48'h0, irq_out);
        get(8'h03, rv);
        chk("rst_cfg", 8'h9B, rv);
        rd(1'b0, rv);
        chk("index_rd", 8'h03, rv);
        // every direction code of group zero
        for (int i = 0; i < 16; i++)
        begin
            code = 8'h80 | {3'b000, i[3], i[2], 1'b0, i[1], i[0]};
            put(8'h03, code);
            get(8'h03, rv);
            chk("cfg_rd", code, rv);
            chk("cfg_oe", {24'h00_0000, {4{~code[3]}}, {4{~code[0]}}, {8{~code[1]}},
                {8{~code[4]}}}, pin_oe);
        end
        // output latches and live inputs
        put(8'h03, 8'h80);
        put(8'h07, 8'h9B);
        put(8'h00, 8'h55);
        put(8'h01, 8'hAA);
        put(8'h02, 8'h0F);
        pc(8'h00, 8'h12);
        @(posedge clk) ext[39:24] <= 16'h3456;
        for (int k = 0; k < 3; k++)
        begin
            get(8'h04 + k[7:0], rv);
            chk("g1_in", ext[24 + 8 * k +: 8], rv);
        end
        @(posedge clk) ext[31:24] <= 8'hA5;
        wt(4);
        get(8'h04, rv);
        chk("g1_live", 8'hA5, rv);
        chk("g0_hold", 24'h0F_AA55, pin_out[23:0]);
        put(8'h07, 8'h80);
        put(8'h04, 8'hC3);
        wt(2);
        chk("g1_out", 48'h0000_C30F_AA55, pin_out);
        get(8'h40, rv);
        chk("unmapped", 8'h00, rv);
        put(8'h07, 8'h0B);
        wt(2);
        chk("c_bit_set", 8'h20, pin_out[47:40]);
        // edge qualified interrupts
        put(8'h03, 8'h89);
        put(8'h07, 8'h89);
        @(posedge clk) jumpers.grp0_edge_irq_setting <= 1'b1;
        @(posedge clk) jumpers.grp1_edge_irq_setting <= 1'b1;
        for (int s = 0; s < 14; s++)
        begin
            clr;
            chk("irq_clr", 48'h0, irq_out);
            pc(tbl[s][23:16], tbl[s][15:8]);
            chk("edge_irq", {8'h00, tbl[s][7:0]}, irq_out);
        end
        @(posedge clk) jumpers.irq_line_select <= 4'h9;
        pc(8'h10, 8'h00);
        clr;
        pc(8'h18, 8'h00);
        chk("irq_line", 16'h0200, irq_out);
        @(posedge clk) jumpers.irq_line_select <= 4'h5;
        // event counter
        pc(8'h00, 8'h00);
        @(posedge clk) jumpers.event_irq_enable <= 1'b1;
        put(8'h83, 8'h30);
        put(8'h80, 8'h03);
        put(8'h80, 8'h00);
        clr;
        for (int n = 1; n <= 3; n++)
        begin
            pc(8'h01, 8'h00);
            pc(8'h00, 8'h00);
            chk("evt_irq", (n == 3) ? 16'h0020 : 16'h0000, irq_out);
            if (n == 2)
            begin
                acc(1'b0, 1'b1, 8'h80);
                rd(1'b1, rv);
                chk("cnt_lsb", 8'h01, rv);
                rd(1'b1, rv);
                chk("cnt_msb", 8'h00, rv);
            end
        end
        wt(20);
        chk("evt_hold", 16'h0020, irq_out);
        @(posedge clk) jumpers.event_irq_enable <= 1'b0;
        clr;
        put(8'h80, 8'h02);
        put(8'h80, 8'h00);
        pc(8'h01, 8'h00);
        pc(8'h00, 8'h00);
        pc(8'h01, 8'h00);
        chk("evt_off", 16'h0000, irq_out);
        // timer pacer, 2 x 3 divisors at the fast clock
        @(posedge clk) jumpers.timer_clock_select <= 1'b1;
        @(posedge clk) jumpers.timer_irq_enable <= 1'b1;
        clr;
        put(8'h83, 8'h74);
        put(8'h83, 8'hB0);
        get(8'h83, rv);
        chk("ccw_rd", 8'hB0, rv);
        put(8'h81, 8'h02);
        put(8'h81, 8'h00);
        put(8'h82, 8'h03);
        put(8'h82, 8'h00);
        wt(250);
        chk("pacer_early", 16'h0000, irq_out);
        for (int w = 0; w < 300 && irq_out === 16'h0000; w++)
            wt(1);
        chk("pacer_irq", 16'h0020, irq_out);
        @(posedge clk) jumpers.timer_irq_enable <= 1'b0;
        clr;
        put(8'h82, 8'h03);
        put(8'h82, 8'h00);
        wt(600);
        chk("pacer_off", 16'h0000, irq_out);
        // slow source, 1 x 2 divisors
        @(posedge clk) jumpers.timer_clock_select <= 1'b0;
        @(posedge clk) jumpers.timer_irq_enable <= 1'b1;
        clr;
        put(8'h81, 8'h01);
        put(8'h81, 8'h00);
        put(8'h82, 8'h02);
        put(8'h82, 8'h00);
        wt(3700);
        chk("slow_early", 16'h0000, irq_out);
        for (int w = 0; w < 4200 && irq_out === 16'h0000; w++)
            wt(1);
        chk("slow_irq", 16'h0020, irq_out);
        summarize;
    end
endmodule // indexed_dio_timer_card_test

// *** tb/pin_env.sv ***
`timescale 1ns/1ns

// ----------------------------------------
// field wiring of both port groups
// ----------------------------------------
module pin_env
(
    input wire logic [47:0] pin_out,
    input wire logic [47:0] pin_oe,
    input wire logic [47:0] ext,
    output dio_pkg::port_pins_type [1:0] pin_in
);
    // driven lines read back the card level, others the field level
    assign pin_in = (pin_out & pin_oe) | (ext & ~pin_oe);
endmodule // pin_env
